// ===== core/lac_learn_seq.sv
// Function
// - Learning runs only while the enable input is high.
// - First learning level is the five-bit base field times eight.
// - Second learning level is first level plus selected increment.
// - Increment codes 00,01,10,11 give 128,16,32,64.
// - Dwell codes 00,01,10,11 give 8,16,24,32 half-cycles per level.
// - Writing one to go starts a run; go clears itself when finished.
// - Complete flag is set when a run finishes.
// - Run drives first level for dwell, then second level for dwell.
// - Loss measured at first level is stored in eleven-bit low constant.
// - Loss measured at second level is stored in eleven-bit high constant.
// - Loss at other currents is linearly interpolated between both constants.
// - After completion motor current moves to the maximum torque limit.
// - Supply compensation rescales both thresholds and loss estimate by supply.
`timescale 1ns/10ps
`default_nettype none

module lac_learn_seq (
    // Clock and reset
    input  wire logic                               sys_clk_i,
    input  wire logic                               rst_n_i,
    // Configuration fields
    input  wire logic                               adaptive_current_enable_i,
    input  wire logic [lac_pkg::BASE_W-1:0]         learn_base_current_i,
    input  wire logic [lac_pkg::SEL_W-1:0]          learn_current_increment_i,
    input  wire logic [lac_pkg::SEL_W-1:0]          learn_dwell_select_i,
    input  wire logic                               learn_go_wr_i,
    input  wire logic                               supply_compensation_enable_i,
    input  wire logic [lac_pkg::CUR_W-1:0]          max_torque_current_limit_i,
    input  wire logic [lac_pkg::CUR_W-1:0]          hysteresis_upper_threshold_i,
    input  wire logic [lac_pkg::CUR_W-1:0]          hysteresis_lower_threshold_i,
    // Software writes of the stored constants
    input  wire logic                               loss_constant_low_level_wr_i,
    input  wire logic                               loss_constant_high_level_wr_i,
    input  wire logic [lac_pkg::CONST_W-1:0]        loss_constant_wdata_i,
    // Motor measurement side
    input  wire logic                               half_cycle_i,
    input  wire logic [lac_pkg::CONST_W-1:0]        measured_loss_i,
    input  wire logic [lac_pkg::CUR_W-1:0]          operating_current_i,
    input  wire logic [lac_pkg::RATIO_W-1:0]        supply_ratio_i,
    // Status and results
    output logic                                    learn_go_o,
    output logic                                    learn_complete_flag_o,
    output logic                                    learning_active_o,
    output logic      [lac_pkg::CUR_W-1:0]          motor_current_o,
    output logic      [lac_pkg::CONST_W-1:0]        loss_constant_low_level_o,
    output logic      [lac_pkg::CONST_W-1:0]        loss_constant_high_level_o,
    output logic      [lac_pkg::CONST_W-1:0]        constant_loss_estimate_o,
    output logic      [lac_pkg::CUR_W-1:0]          hysteresis_upper_eff_o,
    output logic      [lac_pkg::CUR_W-1:0]          hysteresis_lower_eff_o
);

    // ****************************************************************
    // Scaling helper
    // ****************************************************************
    function automatic logic [lac_pkg::CONST_W-1:0] scale_sat(
        input logic [lac_pkg::CONST_W-1:0] value,
        input logic [lac_pkg::RATIO_W-1:0] ratio
    );
        logic [19:0] prod;
        logic [19:0] shifted;
        prod    = value * ratio;
        shifted = prod >> lac_pkg::SCALE_FRAC;
        scale_sat = (|shifted[19:11]) ? lac_pkg::CONST_MAX : shifted[10:0];
    endfunction

    // ****************************************************************
    // State and latched settings
    // ****************************************************************
    lac_pkg::lac_state_type state;
    lac_pkg::lac_state_type next_state;

    // Settings are latched at start so that a careless write mid-run
    // cannot tear the two levels apart.
    logic [lac_pkg::CUR_W-1:0]   level1;
    logic [lac_pkg::CUR_W-1:0]   level2;
    logic [lac_pkg::SHIFT_W-1:0] step_shift;
    logic [lac_pkg::SEL_W-1:0]   dwell_sel;
    logic [lac_pkg::HC_W-1:0]    hc_cnt;
    logic [lac_pkg::ACC_W-1:0]   acc;

    // ****************************************************************
    // Level and dwell decode
    // ****************************************************************
    logic [lac_pkg::CUR_W-1:0]   next_level1;
    logic [lac_pkg::CUR_W-1:0]   step_val;
    logic [lac_pkg::SHIFT_W-1:0] next_step_shift;
    logic [8:0]                  level2_sum;
    logic [lac_pkg::CUR_W-1:0]   next_level2;
    logic [lac_pkg::HC_W-1:0]    dwell_len;
    logic [lac_pkg::HC_W-1:0]    dwell_last;
    logic [lac_pkg::HC_W-1:0]    avg_first;

    assign next_level1 = lac_pkg::CUR_W'({3'h0, learn_base_current_i} << lac_pkg::BASE_SHIFT);
    assign step_val = (learn_current_increment_i == 2'h0) ? lac_pkg::STEP_CODE0 :
                      (learn_current_increment_i == 2'h1) ? lac_pkg::STEP_CODE1 :
                      (learn_current_increment_i == 2'h2) ? lac_pkg::STEP_CODE2 :
                      lac_pkg::STEP_CODE3;
    assign next_step_shift = (learn_current_increment_i == 2'h0) ? lac_pkg::STEP_SHIFT0 :
                             (learn_current_increment_i == 2'h1) ? lac_pkg::STEP_SHIFT1 :
                             (learn_current_increment_i == 2'h2) ? lac_pkg::STEP_SHIFT2 :
                             lac_pkg::STEP_SHIFT3;
    // A second level above full scale is a host error; it saturates.
    assign level2_sum  = {1'b0, next_level1} + {1'b0, step_val};
    assign next_level2 = level2_sum[8] ? lac_pkg::CUR_MAX : level2_sum[7:0];

    assign dwell_len  = lac_pkg::HC_W'(({4'h0, dwell_sel} + 6'h01) << lac_pkg::DWELL_SHIFT);
    assign dwell_last = dwell_len - 6'h01;
    assign avg_first  = dwell_len - lac_pkg::AVG_SAMPLES;

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    // Only the last eight half-cycles of a level are averaged, so the
    // winding current has settled after the jump between levels.
    logic                         running;
    logic                         start;
    logic                         abort;
    logic                         level_end;
    logic                         finish;
    logic                         in_avg;
    logic [lac_pkg::ACC_W-1:0]    acc_sum;
    logic [lac_pkg::CONST_W-1:0]  avg;

    assign running   = (state != lac_pkg::LAC_IDLE);
    assign start     = learn_go_wr_i && adaptive_current_enable_i && !running;
    assign abort     = running && !adaptive_current_enable_i;
    assign level_end = running && half_cycle_i && (hc_cnt == dwell_last);
    assign finish    = level_end && (state == lac_pkg::LAC_LEVEL2) && !abort;
    assign in_avg    = hc_cnt >= avg_first;
    assign acc_sum   = acc + {3'h0, measured_loss_i};
    assign avg       = acc_sum[lac_pkg::AVG_SHIFT +: lac_pkg::CONST_W];

    always_comb begin
        next_state = state;
        unique case (state)
            lac_pkg::LAC_IDLE: begin
                if (start) begin
                    next_state = lac_pkg::LAC_LEVEL1;
                end
            end
            lac_pkg::LAC_LEVEL1: begin
                if (abort) begin
                    next_state = lac_pkg::LAC_IDLE;
                end else if (level_end) begin
                    next_state = lac_pkg::LAC_LEVEL2;
                end
            end
            lac_pkg::LAC_LEVEL2: begin
                if (abort || level_end) begin
                    next_state = lac_pkg::LAC_IDLE;
                end
            end
            default: begin
                next_state = lac_pkg::LAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state      <= lac_pkg::LAC_IDLE;
            level1     <= lac_pkg::CUR_RST;
            level2     <= lac_pkg::CUR_RST;
            step_shift <= lac_pkg::STEP_SHIFT0;
            dwell_sel  <= 2'h0;
        end else begin
            state <= next_state;
            if (start) begin
                level1     <= next_level1;
                level2     <= next_level2;
                step_shift <= next_step_shift;
                dwell_sel  <= learn_dwell_select_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || start || level_end) begin
            hc_cnt <= 6'h00;
            acc    <= 14'h0000;
        end else if (running && half_cycle_i) begin
            hc_cnt <= hc_cnt + 6'h01;
            if (in_avg) begin
                acc <= acc_sum;
            end
        end
    end

    // ****************************************************************
    // Go, complete flag and stored constants
    // ****************************************************************
    logic capture_low;
    logic capture_high;

    assign capture_low  = level_end && (state == lac_pkg::LAC_LEVEL1) && !abort;
    assign capture_high = finish;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            learn_go_o            <= 1'b0;
            learn_complete_flag_o <= 1'b0;
            learning_active_o     <= 1'b0;
        end else begin
            learning_active_o <= (next_state != lac_pkg::LAC_IDLE);
            if (start) begin
                learn_go_o            <= 1'b1;
                learn_complete_flag_o <= 1'b0;
            end else if (finish) begin
                learn_go_o            <= 1'b0;
                learn_complete_flag_o <= 1'b1;
            end else if (abort) begin
                learn_go_o <= 1'b0;
            end
        end
    end

    // A hardware capture wins over a software write in the same cycle.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            loss_constant_low_level_o  <= lac_pkg::CONST_RST;
            loss_constant_high_level_o <= lac_pkg::CONST_RST;
        end else begin
            if (capture_low) begin
                loss_constant_low_level_o <= avg;
            end else if (loss_constant_low_level_wr_i) begin
                loss_constant_low_level_o <= loss_constant_wdata_i;
            end
            if (capture_high) begin
                loss_constant_high_level_o <= avg;
            end else if (loss_constant_high_level_wr_i) begin
                loss_constant_high_level_o <= loss_constant_wdata_i;
            end
        end
    end

    // ****************************************************************
    // Motor current command
    // ****************************************************************
    logic [lac_pkg::CUR_W-1:0] next_motor_current;

    assign next_motor_current = (next_state == lac_pkg::LAC_LEVEL1) ? (start ? next_level1 : level1) :
                                (next_state == lac_pkg::LAC_LEVEL2) ? level2 :
                                max_torque_current_limit_i;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            motor_current_o <= lac_pkg::CUR_RST;
        end else begin
            motor_current_o <= next_motor_current;
        end
    end

    // ****************************************************************
    // Interpolation and supply compensation
    // ****************************************************************
    logic [lac_pkg::CONST_W-1:0] raw_estimate;
    logic [lac_pkg::CONST_W-1:0] upper_scaled;
    logic [lac_pkg::CONST_W-1:0] lower_scaled;
    logic [lac_pkg::CUR_W-1:0]   next_upper;
    logic [lac_pkg::CUR_W-1:0]   next_lower;
    logic [lac_pkg::CONST_W-1:0] next_estimate;

    lac_loss_interp u_interp (
        .sys_clk_i    (sys_clk_i),
        .rst_n_i      (rst_n_i),
        .const_low_i  (loss_constant_low_level_o),
        .const_high_i (loss_constant_high_level_o),
        .base_level_i (level1),
        .step_shift_i (step_shift),
        .current_i    (operating_current_i),
        .estimate_o   (raw_estimate)
    );

    assign upper_scaled  = scale_sat({3'h0, hysteresis_upper_threshold_i}, supply_ratio_i);
    assign lower_scaled  = scale_sat({3'h0, hysteresis_lower_threshold_i}, supply_ratio_i);
    assign next_upper    = !supply_compensation_enable_i ? hysteresis_upper_threshold_i :
                           (|upper_scaled[10:8]) ? lac_pkg::CUR_MAX : upper_scaled[7:0];
    assign next_lower    = !supply_compensation_enable_i ? hysteresis_lower_threshold_i :
                           (|lower_scaled[10:8]) ? lac_pkg::CUR_MAX : lower_scaled[7:0];
    assign next_estimate = supply_compensation_enable_i ?
                           scale_sat(raw_estimate, supply_ratio_i) : raw_estimate;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hysteresis_upper_eff_o   <= lac_pkg::CUR_RST;
            hysteresis_lower_eff_o   <= lac_pkg::CUR_RST;
            constant_loss_estimate_o <= lac_pkg::CONST_RST;
        end else begin
            hysteresis_upper_eff_o   <= next_upper;
            hysteresis_lower_eff_o   <= next_lower;
            constant_loss_estimate_o <= next_estimate;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_enable_gates_go: assert property (
        !adaptive_current_enable_i |=> !learn_go_o && !learning_active_o)
        else $error("learning active while feature disabled");

    a_level1_drive: assert property (
        (state == lac_pkg::LAC_LEVEL1) |-> (motor_current_o == level1) && (level1[2:0] == 3'h0))
        else $error("first level drive wrong");

    a_level2_drive: assert property (
        (state == lac_pkg::LAC_LEVEL2) |-> (motor_current_o == level2) && (level2 >= level1))
        else $error("second level drive wrong");

    a_step_decode: assert property (
        start && (learn_current_increment_i == 2'h1) && (learn_base_current_i == 5'h08)
        |=> (level2 == 8'h50))
        else $error("increment decode wrong");

    a_dwell_switch: assert property (
        (state == lac_pkg::LAC_LEVEL1) && half_cycle_i && (hc_cnt == dwell_last) &&
        adaptive_current_enable_i |=> (state == lac_pkg::LAC_LEVEL2) && (hc_cnt == 6'h00))
        else $error("level switch not at dwell end");

    a_start_run: assert property (
        start |=> learn_go_o && !learn_complete_flag_o && (state == lac_pkg::LAC_LEVEL1))
        else $error("run did not start");

    a_finish_flags: assert property (
        finish |=> !learn_go_o && learn_complete_flag_o && !learning_active_o)
        else $error("finish flags wrong");

    a_capture_low: assert property (
        capture_low |=> (loss_constant_low_level_o == $past(avg)))
        else $error("low constant not captured");

    a_capture_high: assert property (
        capture_high |=> (loss_constant_high_level_o == $past(avg)))
        else $error("high constant not captured");

    a_max_after: assert property (
        finish |=> (motor_current_o == $past(max_torque_current_limit_i)))
        else $error("current not at maximum after run");

    a_comp_bypass: assert property (
        !supply_compensation_enable_i |=> (hysteresis_upper_eff_o ==
        $past(hysteresis_upper_threshold_i)))
        else $error("threshold altered without compensation");

    c_full_run: cover property (finish);
    c_abort_run: cover property (abort);
    c_comp_on: cover property (supply_compensation_enable_i && (supply_ratio_i != 9'h080));

endmodule

`default_nettype wire

// ===== core/lac_pkg.sv
// ****************************************************************
// Shared constants for the learning sequencer
// ****************************************************************
package lac_pkg;

    localparam int CUR_W      = 8;
    localparam int BASE_W     = 5;
    localparam int CONST_W    = 11;
    localparam int SEL_W      = 2;
    localparam int HC_W       = 6;
    localparam int ACC_W      = 14;
    localparam int SHIFT_W    = 3;
    localparam int RATIO_W    = 9;

    // Base field times eight.
    localparam int BASE_SHIFT = 3;

    // Increment selected by the step field.
    localparam logic [CUR_W-1:0]   STEP_CODE0  = 8'h80;
    localparam logic [CUR_W-1:0]   STEP_CODE1  = 8'h10;
    localparam logic [CUR_W-1:0]   STEP_CODE2  = 8'h20;
    localparam logic [CUR_W-1:0]   STEP_CODE3  = 8'h40;
    localparam logic [SHIFT_W-1:0] STEP_SHIFT0 = 3'h7;
    localparam logic [SHIFT_W-1:0] STEP_SHIFT1 = 3'h4;
    localparam logic [SHIFT_W-1:0] STEP_SHIFT2 = 3'h5;
    localparam logic [SHIFT_W-1:0] STEP_SHIFT3 = 3'h6;

    // Dwell is (code + 1) * 8 half-cycles.
    localparam int DWELL_SHIFT = 3;
    localparam logic [HC_W-1:0] AVG_SAMPLES = 6'h08;
    localparam int AVG_SHIFT   = 3;

    // Supply ratio is unsigned with seven fraction bits; 9'h080 means unity.
    localparam int SCALE_FRAC  = 7;

    localparam logic [CUR_W-1:0]   CUR_MAX     = 8'hFF;
    localparam logic [CONST_W-1:0] CONST_MAX   = 11'h7FF;
    localparam logic [CONST_W-1:0] CONST_RST   = 11'h000;
    localparam logic [CUR_W-1:0]   CUR_RST     = 8'h00;

    typedef enum logic [1:0] {
        LAC_IDLE   = 2'b00,
        LAC_LEVEL1 = 2'b01,
        LAC_LEVEL2 = 2'b10
    } lac_state_type;

endpackage

// ===== core/lac_loss_interp.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Linear loss interpolation between the two learned points
// ****************************************************************
module lac_loss_interp (
    // Clock and reset
    input  wire logic                               sys_clk_i,
    input  wire logic                               rst_n_i,
    // Learned points
    input  wire logic [lac_pkg::CONST_W-1:0]        const_low_i,
    input  wire logic [lac_pkg::CONST_W-1:0]        const_high_i,
    input  wire logic [lac_pkg::CUR_W-1:0]          base_level_i,
    input  wire logic [lac_pkg::SHIFT_W-1:0]        step_shift_i,
    // Query
    input  wire logic [lac_pkg::CUR_W-1:0]          current_i,
    output logic      [lac_pkg::CONST_W-1:0]        estimate_o
);

    // The span between the points is a power of two unless the second level saturates, so the
    // division reduces to an arithmetic shift and no divider is needed.
    logic signed [11:0] diff;
    logic signed [8:0]  delta;
    logic signed [20:0] prod;
    logic signed [20:0] quot;
    logic        [21:0] sum;
    logic        [lac_pkg::CONST_W-1:0] next_estimate;

    assign diff  = $signed({1'b0, const_high_i}) - $signed({1'b0, const_low_i});
    assign delta = $signed({1'b0, current_i}) - $signed({1'b0, base_level_i});
    assign prod  = diff * delta;
    assign quot  = prod >>> step_shift_i;
    assign sum   = {quot[20], quot} + {11'h000, const_low_i};
    assign next_estimate = sum[21] ? lac_pkg::CONST_RST :
                           (|sum[20:11]) ? lac_pkg::CONST_MAX :
                           sum[10:0];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            estimate_o <= lac_pkg::CONST_RST;
        end else begin
            estimate_o <= next_estimate;
        end
    end

    a_interp_at_base: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (current_i == base_level_i) |=> (estimate_o == $past(const_low_i)))
        else $error("estimate at base level differs from low constant");

endmodule

`default_nettype wire

// ===== verification/lac_motor_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Unloaded motor: one half-cycle every four clocks, loss tracks current
// ****************************************************************
module lac_motor_model (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // Drive side
    input  wire logic        run_i,
    input  wire logic [7:0]  motor_current_i,
    // Measurement side
    output logic             half_cycle_o,
    output logic      [10:0] measured_loss_o
);
    logic [1:0] phase;
    logic       pulse_now;
    assign pulse_now = run_i && (phase == 2'h3);
    always_ff @(posedge sys_clk_i) begin
        phase <= (rst_n_i && run_i) ? phase + 2'h1 : 2'h0;
        half_cycle_o <= rst_n_i && pulse_now;
        // Off the pulse the bus carries the inverse, so a stale sample cannot pass.
        measured_loss_o <= pulse_now ? {2'h0, motor_current_i, 1'h0} : ~{2'h0, motor_current_i, 1'h0};
    end
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Learning sequencer bench
// ****************************************************************
module tb;
    logic        sys_clk_i = 1'h0;
    logic        rst_n_i = 1'h0;
    logic        en = 1'h0, go_wr = 1'h0, comp = 1'h0, wr_lo = 1'h0, wr_hi = 1'h0;
    logic [4:0]  base = 5'h00;
    logic [1:0]  inc = 2'h0, dwell = 2'h0;
    logic [10:0] wdata = 11'h000, loss, c_lo, c_hi, est;
    logic [7:0]  tmax = 8'hC8, up = 8'h30, lo = 8'h90, op_cur = 8'h00, mcur, up_eff, lo_eff;
    logic [8:0]  ratio = 9'h080;
    logic        hc, go, done, act;
    logic [7:0]  steps [4] = '{8'h80, 8'h10, 8'h20, 8'h40};
    int          bad_count = 0, n_checks = 0;
    initial forever #20 sys_clk_i = ~sys_clk_i;
    lac_learn_seq uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .adaptive_current_enable_i(en),
        .learn_base_current_i(base), .learn_current_increment_i(inc), .learn_dwell_select_i(dwell),
        .learn_go_wr_i(go_wr), .supply_compensation_enable_i(comp),
        .max_torque_current_limit_i(tmax), .hysteresis_upper_threshold_i(up),
        .hysteresis_lower_threshold_i(lo), .loss_constant_low_level_wr_i(wr_lo),
        .loss_constant_high_level_wr_i(wr_hi), .loss_constant_wdata_i(wdata), .half_cycle_i(hc),
        .measured_loss_i(loss), .operating_current_i(op_cur), .supply_ratio_i(ratio),
        .learn_go_o(go), .learn_complete_flag_o(done), .learning_active_o(act),
        .motor_current_o(mcur), .loss_constant_low_level_o(c_lo), .loss_constant_high_level_o(c_hi),
        .constant_loss_estimate_o(est), .hysteresis_upper_eff_o(up_eff),
        .hysteresis_lower_eff_o(lo_eff));
    lac_motor_model motor (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .run_i(act),
        .motor_current_i(mcur), .half_cycle_o(hc), .measured_loss_o(loss));
    task automatic close_out();
        if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // Counts half-cycle pulses the sequencer sees until the motor level moves.
    task automatic wait_move(input logic [7:0] from, output int pulses);
        int t;
        pulses = 0;
        for (t = 0; t < 2000; t++) begin
            @(posedge sys_clk_i);
            if (hc === 1'h1) pulses++;
            #1;
            if (mcur !== from) break;
        end
        if (t == 2000) begin
            bad_count++;
            close_out();
        end
    endtask
    task automatic start(input logic [4:0] b, input logic [1:0] s, input logic [1:0] d);
        @(posedge sys_clk_i);
        base <= b;
        inc <= s;
        dwell <= d;
        go_wr <= 1'h1;
        @(posedge sys_clk_i);
        go_wr <= 1'h0;
        cyc(1);
    endtask
    task automatic run_learn(input logic [4:0] b, input logic [1:0] s, input logic [1:0] d);
        logic [7:0] l1, l2;
        int p, n;
        l1 = {b, 3'h0};
        l2 = l1 + steps[s];
        n = 8 * (d + 1);
        start(b, s, d);
        chk("go", 11'h001, {10'h000, go});
        chk("done", 11'h000, {10'h000, done});
        chk("level1", {3'h0, l1}, {3'h0, mcur});
        wait_move(l1, p);
        chk("dwell1", 11'(n), 11'(p));
        chk("level2", {3'h0, l2}, {3'h0, mcur});
        chk("const_low", {2'h0, l1, 1'h0}, c_lo);
        wait_move(l2, p);
        chk("dwell2", 11'(n), 11'(p));
        chk("const_high", {2'h0, l2, 1'h0}, c_hi);
        chk("motor_max", {3'h0, tmax}, {3'h0, mcur});
        chk("go_clear", 11'h000, {10'h000, go});
        chk("done_set", 11'h001, {10'h000, done});
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_i);
        rst_n_i <= 1'h1;
        start(5'h08, 2'h0, 2'h0);
        chk("no_run_disabled", 11'h000, {10'h000, act});
        @(posedge sys_clk_i);
        en <= 1'h1;
        for (int k = 0; k < 4; k++) begin
            run_learn((k == 0) ? 5'h08 : 5'h14, k[1:0], k[1:0]);
        end
        @(posedge sys_clk_i);
        op_cur <= 8'hC0;
        cyc(4);
        chk("estimate", 11'h180, est);
        @(posedge sys_clk_i);
        comp <= 1'h1;
        ratio <= 9'h100;
        cyc(5);
        chk("upper_eff", 11'h060, {3'h0, up_eff});
        chk("lower_eff", 11'h0FF, {3'h0, lo_eff});
        chk("est_scaled", 11'h300, est);
        @(posedge sys_clk_i);
        comp <= 1'h0;
        start(5'h08, 2'h1, 2'h3);
        chk("done_cleared", 11'h000, {10'h000, done});
        @(posedge sys_clk_i);
        en <= 1'h0;
        cyc(2);
        chk("abort_go", 11'h000, {10'h000, go});
        chk("kept_low", 11'h140, c_lo);
        chk("kept_high", 11'h1C0, c_hi);
        @(posedge sys_clk_i);
        wdata <= 11'h5A5;
        wr_lo <= 1'h1;
        @(posedge sys_clk_i);
        wr_lo <= 1'h0;
        wdata <= 11'h7FF;
        wr_hi <= 1'h1;
        @(posedge sys_clk_i);
        wr_hi <= 1'h0;
        cyc(1);
        chk("sw_low", 11'h5A5, c_lo);
        chk("sw_high", 11'h7FF, c_hi);
        close_out();
    end
endmodule
`default_nettype wire
